// ==== hw/tec_capture.sv ====
// Input-capture unit with AXI4-Lite register slave
//
// Overview of operation
// - Each qualifying event copies the full 16-bit timer count into the result pair.
// - Events: falling edge, rising edge, every 4th or every 16th rising edge.
// - Four-bit mode field in control register bits 3..0 selects event type.
// - Capture sets flag bit 2; it stays set until software clears it.
// - A new capture overwrites an unread earlier value; no overrun guard.
// - With capture pin as output, port writes feed the edge detector.
// - Capture input is port B pin 2 or 3, chosen by config bit 12.
// - Mode changes may raise a false flag; software masks and clears it.
// - Prescaler clears when module is off, not capturing, or in reset.
// - Switching between prescale settings keeps the prescaler count.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tec_capture
   import tec_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  portBIn,
   output var  logic [7:0]  portBOut,
   output var  logic [7:0]  portBOe,
   input  wire logic [15:0] companionTimerCount,
   output var  logic        irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   logic [3:0]  captureModeSelect_reg;
   tec_result_s captureResultPair_reg;
   logic [7:0]  flag_reg;
   logic [7:0]  enable_reg;
   logic [7:0]  portLatch_reg;
   logic [7:0]  portDir_reg;
   logic [15:0] config_reg;
   logic [3:0]  prescale_reg;
   logic [2:0]  pinSync_reg;
   logic        pinState_reg;
   logic [7:0]  awAddr_reg;
   logic        awHeld_reg;
   logic [31:0] wData_reg;
   logic [3:0]  wStrb_reg;
   logic        wHeld_reg;
   logic        flagReadClr;
   logic        doWrite;
   logic        wrLane0;
   logic        wrLane1;
   logic        selPin;
   logic        padLevel;
   logic        pinRise;
   logic        pinFall;
   logic        capMode;
   logic        captureEvent;
   logic [31:0] readData;
   logic        readOk;
   logic        writeOk;

   ////////////////////////////////////////////////////////////////////////////
   // Pin path: three flops on the selected pin, change counted when last two agree

   assign selPin = config_reg[ROUTE_BIT];

   always_comb begin
      padLevel = selPin ? portBIn[PIN_HI] : portBIn[PIN_LO];
      if (!portDir_reg[selPin ? PIN_HI : PIN_LO]) begin
         padLevel = selPin ? portLatch_reg[PIN_HI] : portLatch_reg[PIN_LO];
      end
   end

   // Bit 0 may be metastable; only bits 1 and 2 are trusted
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pinSync_reg  <= 3'b000;
         pinState_reg <= 1'b0;
      end else begin
         pinSync_reg <= {pinSync_reg[1:0], padLevel};
         if (pinSync_reg[1] == pinSync_reg[2]) begin
            pinState_reg <= pinSync_reg[2];
         end
      end
   end

   assign pinRise = (pinSync_reg[2:1] == 2'b11) && !pinState_reg;
   assign pinFall = (pinSync_reg[2:1] == 2'b00) && pinState_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Event selection and prescaler

   assign capMode = (captureModeSelect_reg[3:2] == 2'b01);

   always_comb begin
      captureEvent = 1'b0;
      if (capMode) begin
         unique case (captureModeSelect_reg)
            CAP_FALL:   captureEvent = pinFall;
            CAP_RISE:   captureEvent = pinRise;
            CAP_RISE4:  captureEvent = pinRise && (prescale_reg[1:0] == PS4_LAST[1:0]);
            CAP_RISE16: captureEvent = pinRise && (prescale_reg == PS16_LAST);
            default:    captureEvent = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prescale_reg <= 4'h0;
      end else if (!capMode) begin
         prescale_reg <= 4'h0;
      end else if (pinRise) begin
         prescale_reg <= prescale_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         captureResultPair_reg <= '0;
      end else if (captureEvent) begin
         captureResultPair_reg <= companionTimerCount;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; write address and data taken in either order

   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

   // Address channel: ready pulses once, address parked until the response
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_reg    <= 1'b0;
         awAddr_reg    <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_reg && !s_axi_awready && s_axi_awvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
         end
      end
   end

   // Data channel, taken independently of the address
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wHeld_reg    <= 1'b0;
         wData_reg    <= 32'h0000_0000;
         wStrb_reg    <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !wHeld_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_wready && s_axi_wvalid) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            wHeld_reg <= 1'b0;
         end
      end
   end

   // Response once both halves are parked; a refused write changes nothing
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= writeOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      writeOk = 1'b1;
      unique case (awAddr_reg)
         CTRL_OFF, FLAG_OFF, ENABLE_OFF, PORTB_OFF, CONFIG_OFF: writeOk = 1'b1;
         default: writeOk = 1'b0;
      endcase
   end

   // Register writes, one process per register; lane 1 only reaches 16-bit ones
   assign wrLane0 = doWrite && wStrb_reg[0];
   assign wrLane1 = doWrite && wStrb_reg[1];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         captureModeSelect_reg <= MODE_RST;
      end else if (wrLane0 && awAddr_reg == CTRL_OFF) begin
         captureModeSelect_reg <= wData_reg[MODE_LSB +: MODE_W];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         enable_reg <= ENABLE_RST;
      end else if (wrLane0 && awAddr_reg == ENABLE_OFF) begin
         enable_reg <= wData_reg[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         portLatch_reg <= PORT_RST;
      end else if (wrLane0 && awAddr_reg == PORTB_OFF) begin
         portLatch_reg <= wData_reg[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         portDir_reg <= DIR_RST;
      end else if (wrLane1 && awAddr_reg == PORTB_OFF) begin
         portDir_reg <= wData_reg[15:8];
      end
   end

   // Route bit sits in the upper byte
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         config_reg <= CONFIG_RST;
      end else begin
         if (wrLane0 && awAddr_reg == CONFIG_OFF) begin
            config_reg[7:0] <= wData_reg[7:0];
         end
         if (wrLane1 && awAddr_reg == CONFIG_OFF) begin
            config_reg[15:8] <= wData_reg[15:8];
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flag_reg <= 8'h00;
      end else begin
         if (doWrite && awAddr_reg == FLAG_OFF && wStrb_reg[0]) begin
            flag_reg[FLAG_BIT] <= wData_reg[FLAG_BIT];
         end else if (flagReadClr) begin
            flag_reg[FLAG_BIT] <= 1'b0;
         end
         if (captureEvent) begin
            flag_reg[FLAG_BIT] <= 1'b1;
         end
      end
   end

   // Level interrupt, high while an unmasked flag is set
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flag_reg & enable_reg);
      end
   end

   always_comb begin
      readOk   = 1'b1;
      readData = 32'h0000_0000;
      unique case (s_axi_araddr)
         CTRL_OFF:   readData[3:0] = captureModeSelect_reg;
         RESLO_OFF:  readData[7:0] = captureResultPair_reg.low;
         RESHI_OFF:  readData[7:0] = captureResultPair_reg.high;
         FLAG_OFF:   readData[7:0] = flag_reg;
         ENABLE_OFF: readData[7:0] = enable_reg;
         PORTB_OFF:  readData[15:0] = {portDir_reg, portLatch_reg};
         CONFIG_OFF: readData[15:0] = config_reg;
         TIMER_OFF:  readData[15:0] = companionTimerCount;
         STAT_OFF:   readData[7:0] = flag_reg;
         default:    readOk = 1'b0;
      endcase
   end

   // Status read clears the sticky flag; the flag register itself reads clean
   assign flagReadClr = s_axi_arready && s_axi_arvalid && (s_axi_araddr == STAT_OFF);

   // Address accepted only while no read answer is pending
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= readData;
         s_axi_rresp  <= readOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port B pad drive: enable high while driven (direction bit clear)

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         portBOut <= PORT_RST;
         portBOe  <= 8'h00;
      end else begin
         portBOut <= portLatch_reg;
         portBOe  <= ~portDir_reg;
      end
   end

endmodule : tec_capture
`default_nettype wire

// ==== hw/tec_pkg.sv ====
// Package for the timer edge capture block: offsets, fields, modes, types
package tec_pkg;
   // AXI4-Lite register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] RESLO_OFF  = 8'h04;
   localparam logic [7:0] RESHI_OFF  = 8'h08;
   localparam logic [7:0] FLAG_OFF   = 8'h0C;
   localparam logic [7:0] ENABLE_OFF = 8'h10;
   localparam logic [7:0] PORTB_OFF  = 8'h14;
   localparam logic [7:0] CONFIG_OFF = 8'h18;
   localparam logic [7:0] TIMER_OFF  = 8'h1C;
   localparam logic [7:0] STAT_OFF   = 8'h20;
   // Field positions
   localparam int MODE_LSB       = 0;
   localparam int MODE_W         = 4;
   localparam int FLAG_BIT       = 2;
   localparam int ROUTE_BIT      = 12;
   localparam int TMR_SYNC_BIT   = 0;
   localparam int PIN_LO         = 2;
   localparam int PIN_HI         = 3;
   // Reset values
   localparam logic [3:0]  MODE_RST   = 4'h0;
   localparam logic [7:0]  PORT_RST   = 8'h00;
   localparam logic [7:0]  DIR_RST    = 8'hFF;
   localparam logic [15:0] CONFIG_RST = 16'h0000;
   localparam logic [7:0]  ENABLE_RST = 8'h00;
   // Prescaler counts
   localparam logic [3:0] PS4_LAST  = 4'h3;
   localparam logic [3:0] PS16_LAST = 4'hF;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [3:0] {
      CAP_FALL   = 4'h4,
      CAP_RISE   = 4'h5,
      CAP_RISE4  = 4'h6,
      CAP_RISE16 = 4'h7
   } tec_mode_e;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } tec_result_s;
endpackage : tec_pkg

// ==== testbench/tec_capture_checker.sv ====
// Bus handshake assertions for the timer edge capture block
`timescale 1ns/10ps
`default_nettype none
module tec_capture_checker
   import tec_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   aw_pulse_a: assert property (s_axi_awready |-> s_axi_awvalid ##1 !s_axi_awready)
      else $error("awready not a single taken pulse");
   w_pulse_a: assert property (s_axi_wready |-> s_axi_wvalid ##1 !s_axi_wready)
      else $error("wready not a single taken pulse");
   ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   bad_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr >= 8'h24
      |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h24
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   ok_write_a: assert property (s_axi_awvalid && s_axi_awready &&
      (s_axi_awaddr == CTRL_OFF || s_axi_awaddr == FLAG_OFF || s_axi_awaddr == ENABLE_OFF
      || s_axi_awaddr == PORTB_OFF || s_axi_awaddr == CONFIG_OFF)
      |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("mapped write refused");
endmodule : tec_capture_checker
bind tec_capture tec_capture_checker tec_capture_checker_inst(.core_clk, .resetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ==== testbench/tec_pin_model.sv ====
// Port B pad model: external event source on undriven pins
`timescale 1ns/10ps
`default_nettype none
module tec_pin_model (
   input  wire logic [7:0] portBOut,
   input  wire logic [7:0] portBOe,
   input  wire logic [7:0] ext,
   output var  logic [7:0] portBIn
);
   assign portBIn = (portBOe & portBOut) | (~portBOe & ext);
endmodule : tec_pin_model
`default_nettype wire

// ==== testbench/timer_edge_capture_tb_top.sv ====
// Self-checking bench for the timer edge capture block
`timescale 1ns/10ps
`default_nettype none
module timer_edge_capture_tb_top;
   import tec_pkg::*;
   logic        core_clk = 0, resetn = 0, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic        s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, portBIn, portBOut, portBOe, ext = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] companionTimerCount = 0;
   int          fail_count = 0, n_checks = 0;
   always #10 core_clk = ~core_clk;
   tec_capture tec_capture_inst(.core_clk, .resetn, .portBIn, .portBOut, .portBOe,
      .companionTimerCount, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   tec_pin_model tec_pin_model_inst(.portBOut, .portBOe, .ext, .portBIn);
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk
   task automatic tick(inout int n);
      @(posedge core_clk);
      n++;
      if (n > 40) begin
         fail_count++;
         wrap_up();
      end
   endtask : tick
   task automatic axWr(logic [7:0] a, logic [31:0] d, logic [1:0] e = RESP_OKAY);
      int n = 0;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         tick(n);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk("bresp", e, s_axi_bresp);
   endtask : axWr
   task automatic axRd(logic [7:0] a, logic [31:0] x, logic [31:0] m, logic [1:0] e = RESP_OKAY);
      int n = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         tick(n);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk($sformatf("reg %h", a), x, s_axi_rdata & m);
      chk("rresp", e, s_axi_rresp);
   endtask : axRd
   // timer held on the bench clock around each edge
   task automatic pulse(int p, logic [15:0] t);
      @(posedge core_clk);
      companionTimerCount <= t;
      ext[p] <= 1;
      repeat (8) @(posedge core_clk);
      ext[p] <= 0;
      repeat (8) @(posedge core_clk);
   endtask : pulse
   task automatic cap(logic [15:0] t, logic f);
      axRd(FLAG_OFF, {29'h0, f, 2'h0}, 32'h4);
      if (f) axRd(RESLO_OFF, {24'h0, t[7:0]}, 32'hFF);
      if (f) axRd(RESHI_OFF, {24'h0, t[15:8]}, 32'hFF);
   endtask : cap
   task automatic run(int n, int p);
      for (int k = 1; k <= n; k++) begin
         if (k == n && n > 2) cap(0, 0);
         pulse(p, 16'hA5C3 ^ 16'(k * 257));
      end
      cap(16'hA5C3 ^ 16'(n * 257), 1);
   endtask : run
   task automatic rstChk;
      axRd(CTRL_OFF, {28'h0, MODE_RST}, 32'hF);
      axRd(PORTB_OFF, {16'h0, DIR_RST, PORT_RST}, 32'hFFFF);
      chk("portBOe", 8'h00, portBOe);
   endtask : rstChk
   logic [3:0] md [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
   int         cnt [4] = '{1, 2, 4, 16};
   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1;
      rstChk();
      axWr(8'h40, 32'h1, RESP_SLVERR);
      axRd(8'h40, 0, 32'hFFFFFFFF, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         axWr(CTRL_OFF, 0);
         axWr(CTRL_OFF, {28'h0, md[i]});
         axWr(FLAG_OFF, 0);
         run(cnt[i], 2);
      end
      axWr(CTRL_OFF, 6);
      pulse(2, 0);
      pulse(2, 0);
      axWr(CTRL_OFF, 7);
      axWr(FLAG_OFF, 0);
      run(14, 2);
      axWr(CTRL_OFF, 5);
      axWr(FLAG_OFF, 0);
      axWr(ENABLE_OFF, 4);
      chk("irq", 0, irq);
      pulse(2, 16'h1234);
      chk("irq", 1, irq);
      axWr(ENABLE_OFF, 0);
      repeat (2) @(posedge core_clk);
      chk("irq", 0, irq);
      axWr(ENABLE_OFF, 4);
      repeat (2) @(posedge core_clk);
      chk("irq", 1, irq);
      axRd(FLAG_OFF, 32'h4, 32'h4);
      axRd(STAT_OFF, 32'h4, 32'h4);
      repeat (2) @(posedge core_clk);
      chk("irq", 0, irq);
      axWr(CONFIG_OFF, 32'h1000);
      pulse(2, 16'h4321);
      cap(0, 0);
      run(1, 3);
      axWr(CONFIG_OFF, 0);
      axWr(PORTB_OFF, 32'hFB00);
      axWr(FLAG_OFF, 0);
      companionTimerCount <= 16'h3C96;
      axWr(PORTB_OFF, 32'hFB04);
      repeat (8) @(posedge core_clk);
      cap(16'h3C96, 1);
      chk("pad2", 2'b11, {portBOe[2], portBOut[2]});
      resetn <= 0;
      repeat (2) @(posedge core_clk);
      resetn <= 1;
      rstChk();
      wrap_up();
   end
endmodule : timer_edge_capture_tb_top
`default_nettype wire
